//--- hw/umsdr_regs.sv
// Modem status, scratch and divisor registers of one UART channel
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Change flags set on modem input change
// - Bit 0 flags clear-to-send change
// - Bit 1 flags data-set-ready change
// - Bit 2 flags ring rising edge only
// - Bit 3 flags carrier-detect change
// - Any flag with enable bit 3 interrupts
// - Clear-to-send high halts after current character
// - Bit 4 inverted CTS or RTS loopback
// - Bit 5 inverted DSR or DTR loopback
// - Bit 6 inverted ring or control bit 2
// - Bit 7 inverted carrier or control bit 3
// - Inputs usable as general purpose inputs
// - Free 8-bit scratch register
// - Divisor is high byte then low byte
// - Divisor kept through reset
// - Reset clears flags, upper shows inputs
// - Control bit 4 selects internal loopback
// - Control bit 0 drives terminal-ready low
// - Control bit 1 drives request-to-send low
module umsdr_regs
	import umsdr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ring_indicator_n_i,
	input wire logic carrier_detect_n_i,
	input wire logic tx_char_done_i,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic modem_irq_o,
	output logic tx_halt_o,
	output logic [15:0] divisor_o
);
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	umsdr_modem_s pin_reg;
	umsdr_modem_s prev_reg;
	umsdr_modem_s src;
	logic prime_reg;
	logic [3:0] delta_reg;
	logic [3:0] delta_set;
	logic [7:0] scratch_store_reg;
	logic [7:0] divisor_low_byte_reg;
	logic [7:0] divisor_high_byte_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] interrupt_enable_reg;
	logic dph_reg;
	logic dph_write_reg;
	logic [7:0] dph_addr_reg;
	logic stat_read;
	logic [7:0] modem_status;
	umsdr_txgate_e txgate_reg;

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Pins are active low; three flops before any use
	always_ff @(posedge sys_clk_i) begin
		sync1_reg <= {~carrier_detect_n_i, ~ring_indicator_n_i, ~dsr_n_i, ~cts_n_i};
		sync2_reg <= sync1_reg;
		pin_reg <= sync2_reg;
	end

	// Loopback swaps pin sources for control bits
	always_comb begin
		if (modem_control_reg[UMSDR_MCTL_LOOP]) begin
			src.cts = modem_control_reg[UMSDR_MCTL_RTS];
			src.dsr = modem_control_reg[UMSDR_MCTL_DTR];
			src.ri = modem_control_reg[UMSDR_MCTL_OP1];
			src.cd = modem_control_reg[UMSDR_MCTL_OP2];
		end else begin
			src = pin_reg;
		end
	end

	// Previous value has no reset; prime_reg masks edges in the cycle after reset so no false edge is seen
	always_ff @(posedge sys_clk_i) begin
		prev_reg <= src;
		if (sys_rst_i) begin
			prime_reg <= 1'b0;
		end else begin
			prime_reg <= 1'b1;
		end
	end

	always_comb begin
		delta_set = 4'h0;
		if (prime_reg) begin
			delta_set[0] = src.cts ^ prev_reg.cts;
			delta_set[1] = src.dsr ^ prev_reg.dsr;
			// Ring flag: pin rising means status bit falling
			delta_set[2] = prev_reg.ri & ~src.ri;
			delta_set[3] = src.cd ^ prev_reg.cd;
		end
	end

	assign modem_status = {src.cd, src.ri, src.dsr, src.cts, delta_reg};

	// AHB data phase tracking; slave is zero wait state
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dph_reg <= 1'b0;
			dph_write_reg <= 1'b0;
			dph_addr_reg <= 8'h00;
		end else if (hready_i) begin
			dph_reg <= hsel_i & htrans_i[1];
			dph_write_reg <= hsel_i & htrans_i[1] & hwrite_i;
			dph_addr_reg <= haddr_i;
		end
	end

	// Clear happens in the address phase; the read data is captured at the same edge
	assign stat_read = hsel_i & htrans_i[1] & ~hwrite_i & hready_i
		& is_addr(haddr_i, UMSDR_OFF_STAT);

	// New change in the read cycle survives the clear
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			delta_reg <= 4'h0;
		end else if (dph_write_reg && is_addr(dph_addr_reg, UMSDR_OFF_STAT)) begin
			delta_reg <= hwdata_i[3:0] | delta_set;
		end else if (stat_read) begin
			delta_reg <= delta_set;
		end else begin
			delta_reg <= delta_reg | delta_set;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			scratch_store_reg <= UMSDR_SCR_RST;
			modem_control_reg <= UMSDR_MCTL_RST;
			interrupt_enable_reg <= UMSDR_IEN_RST;
		end else if (dph_write_reg) begin
			if (is_addr(dph_addr_reg, UMSDR_OFF_SCR)) begin
				scratch_store_reg <= hwdata_i[7:0];
			end
			// Upper control bits are reserved and always read zero
			if (is_addr(dph_addr_reg, UMSDR_OFF_MCTL)) begin
				modem_control_reg <= {3'h0, hwdata_i[4:0]};
			end
			if (is_addr(dph_addr_reg, UMSDR_OFF_IEN)) begin
				interrupt_enable_reg <= hwdata_i[7:0];
			end
		end
	end

	// No reset term: divisor survives the reset pin
	always_ff @(posedge sys_clk_i) begin
		if (dph_write_reg && is_addr(dph_addr_reg, UMSDR_OFF_DIVLO)) begin
			divisor_low_byte_reg <= hwdata_i[7:0];
		end
		if (dph_write_reg && is_addr(dph_addr_reg, UMSDR_OFF_DIVHI)) begin
			divisor_high_byte_reg <= hwdata_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		divisor_o <= {divisor_high_byte_reg, divisor_low_byte_reg};
	end

	// Read mux registered in the address phase
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
			case (haddr_i)
				UMSDR_OFF_STAT: hrdata_o <= {24'h0, modem_status};
				UMSDR_OFF_SCR: hrdata_o <= {24'h0, scratch_store_reg};
				UMSDR_OFF_DIVLO: hrdata_o <= {24'h0, divisor_low_byte_reg};
				UMSDR_OFF_DIVHI: hrdata_o <= {24'h0, divisor_high_byte_reg};
				UMSDR_OFF_MCTL: hrdata_o <= {24'h0, modem_control_reg};
				UMSDR_OFF_IEN: hrdata_o <= {24'h0, interrupt_enable_reg};
				UMSDR_OFF_CTL: hrdata_o <= {31'h0, tx_halt_o};
				default: hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// Active-low modem outputs from control bits
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dtr_n_o <= 1'b1;
			rts_n_o <= 1'b1;
		end else begin
			dtr_n_o <= ~modem_control_reg[UMSDR_MCTL_DTR];
			rts_n_o <= ~modem_control_reg[UMSDR_MCTL_RTS];
		end
	end

	// Interrupt follows flags one edge after they update
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			modem_irq_o <= 1'b0;
		end else begin
			modem_irq_o <= interrupt_enable_reg[UMSDR_IEN_MS] & (|delta_reg);
		end
	end

	// Halt only takes effect at a character boundary; output is the state flop's twin
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			txgate_reg <= UMSDR_TX_RUN;
			tx_halt_o <= 1'b0;
		end else begin
			case (txgate_reg)
				UMSDR_TX_RUN: begin
					if (!src.cts && tx_char_done_i) begin
						txgate_reg <= UMSDR_TX_HALT;
						tx_halt_o <= 1'b1;
					end
				end
				UMSDR_TX_HALT: begin
					// Resume may cut in mid-gap; the transmitter restarts on its own boundary
					if (src.cts) begin
						txgate_reg <= UMSDR_TX_RUN;
						tx_halt_o <= 1'b0;
					end
				end
				default: begin
					txgate_reg <= UMSDR_TX_RUN;
					tx_halt_o <= 1'b0;
				end
			endcase
		end
	end

	// Steps of a status read and of a transmit halt
	sequence s_stat_read;
		stat_read && delta_set == 4'h0 && !dph_write_reg;
	endsequence
	sequence s_flags_clear;
		delta_reg == 4'h0 ##1 !modem_irq_o;
	endsequence
	sequence s_char_end;
		!tx_halt_o && !src.cts && tx_char_done_i;
	endsequence
	sequence s_cts_release;
		tx_halt_o && src.cts;
	endsequence

	// Interrupt and flag behaviour
	a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		modem_irq_o == $past(interrupt_enable_reg[UMSDR_IEN_MS] & (|delta_reg)))
		else $error("modem irq mismatch");
	a_ri_edge: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && !prev_reg.ri && src.ri && !stat_read && !delta_reg[2]) |=> !delta_reg[2])
		else $error("ring flag set on falling edge");
	a_ri_rise: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && prev_reg.ri && !src.ri) |=> delta_reg[2])
		else $error("ring end missed");
	a_cts_delta: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && src.cts != prev_reg.cts) |=> delta_reg[0])
		else $error("cts change missed");
	a_cts_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && src.cts == prev_reg.cts && stat_read && !dph_write_reg) |=> !delta_reg[0])
		else $error("cts flag set without change");
	a_dsr_delta: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && src.dsr != prev_reg.dsr) |=> delta_reg[1])
		else $error("dsr change missed");
	a_cd_delta: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(prime_reg && src.cd != prev_reg.cd) |=> delta_reg[3])
		else $error("carrier change missed");
	a_flag_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!stat_read && !(dph_write_reg && is_addr(dph_addr_reg, UMSDR_OFF_STAT)))
		|=> (delta_reg & $past(delta_reg)) == $past(delta_reg))
		else $error("change flag lost without read");
	a_read_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_stat_read |=> delta_reg == 4'h0)
		else $error("status read did not clear flags");
	a_irq_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_stat_read |=> s_flags_clear)
		else $error("status read did not drop irq");
	a_read_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		stat_read |=> hrdata_o[7:0] == $past(modem_status))
		else $error("status read data wrong");
	a_reset_flags: assert property (@(posedge sys_clk_i)
		sys_rst_i |=> delta_reg == 4'h0)
		else $error("flags not cleared by reset");

	// Input path and loopback sources
	a_sync_chain: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		pin_reg == $past(sync1_reg, 2))
		else $error("synchroniser chain broken");
	a_pin_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!modem_control_reg[UMSDR_MCTL_LOOP] |-> modem_status[7:4] == pin_reg)
		else $error("status upper bits not from pins");
	a_loop_rts: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		modem_control_reg[UMSDR_MCTL_LOOP] |-> modem_status[4] == modem_control_reg[1])
		else $error("loopback cts bit wrong");
	a_loop_dsr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		modem_control_reg[UMSDR_MCTL_LOOP] |-> modem_status[5] == modem_control_reg[0])
		else $error("loopback dsr bit wrong");
	a_loop_ri: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		modem_control_reg[UMSDR_MCTL_LOOP] |-> modem_status[6] == modem_control_reg[2])
		else $error("loopback ring bit wrong");
	a_loop_cd: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		modem_control_reg[UMSDR_MCTL_LOOP] |-> modem_status[7] == modem_control_reg[3])
		else $error("loopback carrier bit wrong");

	// Control outputs and scratch write
	a_dtr_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$past(modem_control_reg[UMSDR_MCTL_DTR]) |-> !dtr_n_o)
		else $error("dtr pin not low");
	a_dtr_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!$past(modem_control_reg[UMSDR_MCTL_DTR]) |-> dtr_n_o)
		else $error("dtr pin not high");
	a_rts_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$past(modem_control_reg[UMSDR_MCTL_RTS]) |-> !rts_n_o)
		else $error("rts pin not low");
	a_rts_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!$past(modem_control_reg[UMSDR_MCTL_RTS]) |-> rts_n_o)
		else $error("rts pin not high");
	a_reset_outs: assert property (@(posedge sys_clk_i)
		sys_rst_i |=> (dtr_n_o && rts_n_o && !modem_irq_o && !tx_halt_o))
		else $error("outputs not at reset level");
	a_scratch_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(dph_write_reg && is_addr(dph_addr_reg, UMSDR_OFF_SCR))
		|=> scratch_store_reg == $past(hwdata_i[7:0]))
		else $error("scratch write lost");

	// Transmit halt
	a_halt_wait: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!tx_halt_o && !tx_char_done_i) |=> !tx_halt_o)
		else $error("halt before character end");
	a_halt_enter: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_char_end |=> tx_halt_o)
		else $error("halt not entered");
	a_halt_resume: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		s_cts_release |=> !tx_halt_o)
		else $error("transmit not resumed");
endmodule

//--- hw/umsdr_pkg.sv
// Package for the modem status, scratch and divisor register block
package umsdr_pkg;
	localparam logic [7:0] UMSDR_OFF_STAT = 8'h00;
	localparam logic [7:0] UMSDR_OFF_SCR = 8'h04;
	localparam logic [7:0] UMSDR_OFF_DIVLO = 8'h08;
	localparam logic [7:0] UMSDR_OFF_DIVHI = 8'h0c;
	localparam logic [7:0] UMSDR_OFF_MCTL = 8'h10;
	localparam logic [7:0] UMSDR_OFF_IEN = 8'h14;
	localparam logic [7:0] UMSDR_OFF_CTL = 8'h18;
	localparam logic [7:0] UMSDR_SCR_RST = 8'hff;
	localparam logic [7:0] UMSDR_MCTL_RST = 8'h00;
	localparam logic [7:0] UMSDR_IEN_RST = 8'h00;
	localparam int UMSDR_MCTL_DTR = 0;
	localparam int UMSDR_MCTL_RTS = 1;
	localparam int UMSDR_MCTL_OP1 = 2;
	localparam int UMSDR_MCTL_OP2 = 3;
	localparam int UMSDR_MCTL_LOOP = 4;
	localparam int UMSDR_IEN_MS = 3;
	localparam logic [1:0] UMSDR_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] UMSDR_HTRANS_SEQ = 2'h3;

	// Modem inputs, active high (already inverted from the pins)
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} umsdr_modem_s;

	typedef enum logic [0:0] {
		UMSDR_TX_RUN = 1'b0,
		UMSDR_TX_HALT = 1'b1
	} umsdr_txgate_e;
endpackage

//--- bench/umsdr_modem_model.sv
// Modem model driving the four active-low status pins
`timescale 1ns/1ps
module umsdr_modem_model
	import umsdr_pkg::*;
(
	input wire umsdr_modem_s lines_i,
	output logic cts_n_o,
	output logic dsr_n_o,
	output logic ring_indicator_n_o,
	output logic carrier_detect_n_o
);
	// Pins are always driven, so no released level to model
	assign cts_n_o = ~lines_i.cts;
	assign dsr_n_o = ~lines_i.dsr;
	assign ring_indicator_n_o = ~lines_i.ri;
	assign carrier_detect_n_o = ~lines_i.cd;
endmodule

//--- bench/tb.sv
// Testbench for the modem status, scratch and divisor registers
`timescale 1ns/1ps
module tb
	import umsdr_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [7:0] haddr_i = 8'h00;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic tx_char_done_i = 1'b0;
	umsdr_modem_s lines = 4'h9;
	wire logic [31:0] hrdata_o;
	wire logic [15:0] divisor_o;
	wire logic hreadyout_o, hresp_o, dtr_n_o, rts_n_o, modem_irq_o, tx_halt_o;
	wire logic cts_n, dsr_n, ri_n, cd_n;
	logic [31:0] rd;
	int mismatches = 0;
	int checks_done = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	umsdr_modem_model i_umsdr_modem_model(.lines_i(lines), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
		.ring_indicator_n_o(ri_n), .carrier_detect_n_o(cd_n));
	umsdr_regs i_umsdr_regs(.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
		.ring_indicator_n_i(ri_n), .carrier_detect_n_i(cd_n), .tx_char_done_i(tx_char_done_i),
		.dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .modem_irq_o(modem_irq_o),
		.tx_halt_o(tx_halt_o), .divisor_o(divisor_o));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= wr;
		htrans_i <= UMSDR_HTRANS_NONSEQ;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wait8;
		repeat (8) @(posedge sys_clk_i);
	endtask
	task automatic t_reset;
		rdchk(UMSDR_OFF_STAT, 32'h90);
		rdchk(UMSDR_OFF_SCR, 32'hff);
		chk({30'h0, dtr_n_o, rts_n_o}, 32'h3);
		chk({30'h0, hreadyout_o, hresp_o}, 32'h2);
		bus(1'b1, UMSDR_OFF_SCR, 32'h5a);
		rdchk(UMSDR_OFF_SCR, 32'h5a);
		rdchk(UMSDR_OFF_STAT, 32'h90);
		bus(1'b1, 8'h1c, 32'h77);
		rdchk(8'h1c, 32'h0);
	endtask
	task automatic t_div;
		bus(1'b1, UMSDR_OFF_DIVLO, 32'h34);
		bus(1'b1, UMSDR_OFF_DIVHI, 32'h12);
		// Divisor output is one flop behind the registers
		repeat (2) @(posedge sys_clk_i);
		chk({16'h0, divisor_o}, 32'h1234);
		sys_rst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		chk({16'h0, divisor_o}, 32'h1234);
		rdchk(UMSDR_OFF_DIVHI, 32'h12);
		rdchk(UMSDR_OFF_SCR, 32'hff);
	endtask
	task automatic t_flags;
		logic [3:0] f;
		bus(1'b1, UMSDR_OFF_IEN, 32'h8);
		for (int n = 0; n < 8; n++) begin
			@(posedge sys_clk_i);
			lines <= lines ^ (4'h1 << (n % 4));
			wait8;
			f = (n % 4 == 2) ? {1'b0, ~lines.ri, 2'b0} : 4'h1 << (n % 4);
			chk({31'h0, modem_irq_o}, {31'h0, f != 4'h0});
			rdchk(UMSDR_OFF_STAT, {24'h0, lines, f});
			rdchk(UMSDR_OFF_STAT, {24'h0, lines, 4'h0});
			chk({31'h0, modem_irq_o}, 32'h0);
		end
		bus(1'b1, UMSDR_OFF_IEN, 32'h0);
		@(posedge sys_clk_i);
		lines <= lines ^ 4'h1;
		wait8;
		chk({31'h0, modem_irq_o}, 32'h0);
		rdchk(UMSDR_OFF_STAT, {24'h0, lines, 4'h1});
	endtask
	task automatic t_loop;
		logic [3:0] m [4] = '{4'h2, 4'h1, 4'h4, 4'h8};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, UMSDR_OFF_MCTL, 32'h10 | (32'h1 << i));
			wait8;
			bus(1'b0, UMSDR_OFF_STAT, 32'h0);
			chk({28'h0, rd[7:4]}, {28'h0, m[i]});
		end
		bus(1'b1, UMSDR_OFF_MCTL, 32'h3);
		wait8;
		bus(1'b0, UMSDR_OFF_STAT, 32'h0);
		chk({24'h0, rd[7:4], dtr_n_o, rts_n_o, 2'h0}, {24'h0, lines, 4'h0});
	endtask
	task automatic t_halt;
		chk({31'h0, tx_halt_o}, 32'h0);
		@(posedge sys_clk_i);
		tx_char_done_i <= 1'b1;
		@(posedge sys_clk_i);
		tx_char_done_i <= 1'b0;
		@(posedge sys_clk_i);
		chk({31'h0, tx_halt_o}, 32'h1);
		rdchk(UMSDR_OFF_CTL, 32'h1);
		lines <= lines ^ 4'h1;
		wait8;
		chk({31'h0, tx_halt_o}, 32'h0);
	endtask
	// Status register is never written by the bench
	initial begin
		repeat (5) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_div;
		t_flags;
		t_loop;
		t_halt;
		stop_test;
	end
	initial begin
		#100000;
		mismatches++;
		stop_test;
	end
endmodule
